/* File: pkg/acc_map.vh */
// Register map, field positions, reset values and cycle counts of the converter control block
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// Byte addresses of the registers
`define ACC_CTL0_ADDR 12'hf70
`define ACC_CTL1_ADDR 12'hf74
`define ACC_DATA_H_ADDR 12'hf78
`define ACC_DATA_L_ADDR 12'hf7c
`define ACC_IRQ_STAT_ADDR 12'hf80
`define ACC_IRQ_MASK_ADDR 12'hf84

// Fields of converter_control_zero
`define ACC_CTL0_GO 7
`define ACC_CTL0_REF_LOW 6
`define ACC_CTL0_DRIVE_OUT 5
`define ACC_CTL0_REPEAT 4
`define ACC_CTL0_CHAN_HI 3
`define ACC_CTL0_CHAN_LO 0

// Fields of the second control register
`define ACC_CTL1_ENABLE 7
`define ACC_CTL1_REF_HIGH 0

// Interrupt status and mask layout
`define ACC_IRQ_DONE 0

// Reset values
`define ACC_CTL0_RESET 8'h00
`define ACC_CTL1_RESET 8'h81
`define ACC_IRQ_MASK_RESET 1'b0

// Reference level codes
`define ACC_REF_EXTERNAL 2'h0
`define ACC_REF_1V0 2'h1
`define ACC_REF_2V0 2'h2
`define ACC_REF_RESERVED 2'h3

// Conversion timing in system clock cycles
`define ACC_FIRST_CYCLES 5129
`define ACC_REPEAT_CYCLES 256

// Channel code of the internal temperature sensor; arbitrary default
`define ACC_TEMP_CHANNEL 4'he

`endif

/* File: rtl/acc_adc_ctrl.v */
// Conversion control for the on-chip converter with an APB register slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "acc_map.vh"

module acc_adc_ctrl #(
  parameter FIRST_CYCLES = `ACC_FIRST_CYCLES,
  parameter REPEAT_CYCLES = `ACC_REPEAT_CYCLES,
  parameter COUNT_W = 15,
  parameter [3:0] TEMP_CHANNEL = `ACC_TEMP_CHANNEL
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Interrupt
  output wire irq,
  // Converter core
  input wire [12:0] core_result,
  output reg core_start,
  output reg core_sample,
  output reg core_busy,
  output reg [3:0] core_channel,
  output wire [1:0] core_ref_level,
  output wire core_ref_buf_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg conversion_go;
  reg ref_level_low_bit;
  reg ref_drive_out;
  reg repeat_mode;
  reg [3:0] input_channel_select;
  reg ref_level_high_bit;
  reg conv_enable;
  reg [12:0] result;
  reg irq_status;
  reg irq_mask;
  reg [COUNT_W-1:0] count;
  reg temp_sel;
  wire setup_phase;
  wire wr_access;
  wire wr_ctl0;
  wire wr_ctl1;
  wire wr_stat;
  wire wr_mask;
  wire start_req;
  wire conv_done;
  wire chan_is_temp;
  wire [COUNT_W-1:0] first_count;
  wire [COUNT_W-1:0] repeat_count;
  wire [7:0] ctl0_value;
  wire [7:0] ctl1_value;
  reg [31:0] next_prdata;
  reg next_pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states, so pready stays high
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign wr_ctl0 = wr_access & (paddr == `ACC_CTL0_ADDR);
  assign wr_ctl1 = wr_access & (paddr == `ACC_CTL1_ADDR);
  assign wr_stat = wr_access & (paddr == `ACC_IRQ_STAT_ADDR);
  assign wr_mask = wr_access & (paddr == `ACC_IRQ_MASK_ADDR);

  // Only a written one launches; a written zero leaves the sequence alone
  assign start_req = wr_ctl0 & pwdata[`ACC_CTL0_GO] & conv_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Interval lengths; the temperature sensor needs twice as long
  assign chan_is_temp = (pwdata[`ACC_CTL0_CHAN_HI:`ACC_CTL0_CHAN_LO] == TEMP_CHANNEL);
  assign first_count = chan_is_temp ? FIRST_CYCLES[COUNT_W-2:0] << 1 : FIRST_CYCLES[COUNT_W-1:0];
  assign repeat_count = temp_sel ? REPEAT_CYCLES[COUNT_W-2:0] << 1 : REPEAT_CYCLES[COUNT_W-1:0];

  // Last cycle of an interval
  assign conv_done = core_busy & (count == {{(COUNT_W-1){1'b0}}, 1'b1});

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields other than conversion_go
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_level_low_bit <= 1'b0;
      ref_drive_out <= 1'b0;
      repeat_mode <= 1'b0;
      input_channel_select <= 4'h0;
      ref_level_high_bit <= 1'b1;
      conv_enable <= 1'b1;
    end else begin
      if (wr_ctl0) begin
        ref_level_low_bit <= pwdata[`ACC_CTL0_REF_LOW];
        ref_drive_out <= pwdata[`ACC_CTL0_DRIVE_OUT];
        repeat_mode <= pwdata[`ACC_CTL0_REPEAT];
        input_channel_select <= pwdata[`ACC_CTL0_CHAN_HI:`ACC_CTL0_CHAN_LO];
      end
      if (wr_ctl1) begin
        ref_level_high_bit <= pwdata[`ACC_CTL1_REF_HIGH];
        conv_enable <= pwdata[`ACC_CTL1_ENABLE];
      end
    end
  end

  // Reference goes straight to the core; the reserved code is passed too
  assign core_ref_level = {ref_level_high_bit, ref_level_low_bit};
  // No interlock with the external source, software keeps that combination out
  assign core_ref_buf_en = ref_drive_out;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: a start always wins over completion or repeat
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_go <= 1'b0;
      core_busy <= 1'b0;
      count <= {COUNT_W{1'b0}};
      temp_sel <= 1'b0;
      core_channel <= 4'h0;
      core_start <= 1'b0;
      core_sample <= 1'b0;
    end else begin
      core_start <= start_req;
      core_sample <= conv_done & conv_enable & ~start_req;
      if (start_req) begin
        conversion_go <= 1'b1;
        core_busy <= 1'b1;
        count <= first_count;
        temp_sel <= chan_is_temp;
        core_channel <= pwdata[`ACC_CTL0_CHAN_HI:`ACC_CTL0_CHAN_LO];
      end else if (!conv_enable) begin
        // Disable abandons the sequence without a result
        conversion_go <= 1'b0;
        core_busy <= 1'b0;
        count <= {COUNT_W{1'b0}};
      end else if (conv_done) begin
        conversion_go <= 1'b0;
        if (repeat_mode) begin
          count <= repeat_count;
        end else begin
          core_busy <= 1'b0;
          count <= {COUNT_W{1'b0}};
        end
      end else if (core_busy) begin
        count <= count - {{(COUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture at each completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 13'h0000;
    end else if (conv_done & conv_enable & ~start_req) begin
      result <= core_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky completion flag; a new event beats a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 1'b0;
    end else if (conv_done & conv_enable & ~start_req) begin
      irq_status <= 1'b1;
    end else if (wr_stat & pwdata[`ACC_IRQ_DONE]) begin
      irq_status <= 1'b0;
    end
  end

  // Interrupt mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `ACC_IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask <= pwdata[`ACC_IRQ_DONE];
    end
  end

  // Level output; disabling does not drop a pending request
  assign irq = irq_status & irq_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, captured in the setup cycle so prdata comes from a flop
  assign ctl0_value = {conversion_go, ref_level_low_bit, ref_drive_out, repeat_mode, input_channel_select};
  assign ctl1_value = {conv_enable, 6'h00, ref_level_high_bit};

  always @* begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `ACC_CTL0_ADDR: begin
        next_prdata = {24'h000000, ctl0_value};
      end
      `ACC_CTL1_ADDR: begin
        next_prdata = {24'h000000, ctl1_value};
      end
      `ACC_DATA_H_ADDR: begin
        next_prdata = {24'h000000, result[12:5]};
      end
      `ACC_DATA_L_ADDR: begin
        next_prdata = {24'h000000, result[4:0], 3'h0};
      end
      `ACC_IRQ_STAT_ADDR: begin
        next_prdata = {31'h00000000, irq_status};
      end
      `ACC_IRQ_MASK_ADDR: begin
        next_prdata = {31'h00000000, irq_mask};
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // A value changing during the access cycle shows its setup-cycle state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule // acc_adc_ctrl

/* File: test/acc_core_model.sv */
// Behavioural converter core feeding results to the control block
`timescale 1ns/1ps
module acc_core_model (
  // Clock and control from the block
  input wire pclk,
  input wire core_busy,
  input wire [3:0] core_channel,
  // Result toward the block
  output logic [12:0] core_result
);
  logic [12:0] junk = 13'h0aaa;
  // Churns while idle so a stale capture cannot pass as a result
  always @(posedge pclk) junk <= ~junk ^ 13'h0001;
  // Channel-tagged value while converting
  assign core_result = core_busy ? {~core_channel, 9'h1a5} : junk;
endmodule // acc_core_model

/* File: test/acc_adc_ctrl_sva.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module acc_adc_ctrl_sva #(
  parameter int FIRST_CYCLES = 5129,
  parameter int REPEAT_CYCLES = 256,
  parameter int COUNT_W = 15,
  parameter logic [3:0] TEMP_CHANNEL = 4'he
) (
  // Clock, reset and bus
  input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // Interrupt and converter core
  input wire irq, core_start, core_sample, core_busy, core_ref_buf_en,
  input wire [12:0] core_result,
  input wire [3:0] core_channel,
  input wire [1:0] core_ref_level
);
  logic [15:0] gap;
  logic from_go;
  int want;
  wire mapped = paddr >= 12'hf70 && paddr <= 12'hf84 && paddr[1:0] == 2'h0;
  // Edges since the last launch or result; a launch restarts the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 16'h0;
      from_go <= 1'b0;
    end else if (core_start || core_sample) begin
      gap <= 16'h1;
      from_go <= core_start;
    end else begin
      gap <= gap + 16'h1;
    end
  end
  // Interval owed to the next result; temperature doubles it
  assign want = (from_go ? FIRST_CYCLES : REPEAT_CYCLES) * (core_channel == TEMP_CHANNEL ? 2 : 1);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_result_gap: assert property (core_sample |-> gap == want)
    else $error("result interval wrong");
  chk_launch_busy: assert property (core_start |-> core_busy)
    else $error("launch without busy");
  chk_busy_cause: assert property ($rose(core_busy) |-> core_start)
    else $error("busy without launch");
  chk_launch_pulse: assert property (core_start |=> !core_start)
    else $error("launch pulse too long");
  chk_sample_pulse: assert property (core_sample |=> !core_sample)
    else $error("result pulse too long");
  chk_chan_hold: assert property ($changed(core_channel) |-> core_start)
    else $error("channel moved outside launch");
  chk_irq_cause: assert property ($rose(irq) |-> core_sample || $past(psel && penable && pwrite))
    else $error("interrupt without cause");
  chk_write_rdata: assert property (psel && penable && pwrite |-> prdata == 32'h0 && pready)
    else $error("read data on write");
  chk_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error wrong");
endmodule // acc_adc_ctrl_sva
bind acc_adc_ctrl acc_adc_ctrl_sva #(.FIRST_CYCLES(FIRST_CYCLES), .REPEAT_CYCLES(REPEAT_CYCLES),
  .COUNT_W(COUNT_W), .TEMP_CHANNEL(TEMP_CHANNEL)) acc_adc_ctrl_sva_inst (.*);

/* File: test/tb_top.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "acc_map.vh"
module tb_top;
  localparam int FIRST = 20;
  localparam int REP = 6;
  localparam logic [11:0] A0 = `ACC_CTL0_ADDR, A1 = `ACC_CTL1_ADDR, ST = `ACC_IRQ_STAT_ADDR;
  localparam logic [11:0] DH = `ACC_DATA_H_ADDR, DL = `ACC_DATA_L_ADDR, MK = `ACC_IRQ_MASK_ADDR;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  wire pready, pslverr, irq, core_start, core_sample, core_busy, core_ref_buf_en;
  wire [31:0] prdata;
  wire [12:0] core_result;
  wire [3:0] core_channel;
  wire [1:0] core_ref_level;
  int n_fail = 0;
  int checked = 0;
  acc_adc_ctrl #(.FIRST_CYCLES(FIRST), .REPEAT_CYCLES(REP)) acc_adc_ctrl_inst (.*);
  acc_core_model acc_core_model_inst (.*);
  initial forever #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; returns at the next falling edge so outputs have settled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Counts falling edges until a result pulse, bounded
  task automatic wait_sample(input int exp);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (core_sample !== 1'b1 && n < 200);
    check(n, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(A0, 32'h0);
    rchk(A1, 32'h81);
    check(core_ref_level, 2'h2);
    check(core_ref_buf_en, 1'b0);
    rchk(12'h0f0, 32'h0);
    check(er, 1'b1);
  endtask
  // Every reference code; drive-out kept low for the external source
  task automatic t_refs;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, A1, {24'h0, 1'b1, 6'h0, k[1]});
      apb(1'b1, A0, {24'h0, 1'b0, k[0], k != 0, 5'h0});
      check(core_ref_level, k[1:0]);
      check(core_ref_buf_en, k != 0);
    end
    apb(1'b1, A1, 32'h81);
    apb(1'b1, A0, 32'h0);
  endtask
  task automatic t_single(input logic [3:0] ch, input int cyc);
    logic [12:0] r;
    r = {~ch, 9'h1a5};
    apb(1'b1, A0, {24'h0, 4'h8, ch});
    wait_sample(cyc);
    check(core_channel, ch);
    rchk(A0, {28'h0, ch});
    rchk(DH, r[12:5]);
    rchk(DL, {r[4:0], 3'h0});
    check(irq, 1'b1);
    apb(1'b1, MK, 32'h0);
    check(irq, 1'b0);
    apb(1'b1, MK, 32'h1);
    apb(1'b1, ST, 32'h1);
    check(irq, 1'b0);
  endtask
  // Zero write mid-run is ignored, a second go restarts the count
  task automatic t_restart;
    apb(1'b1, A0, 32'h82);
    repeat (4) @(negedge pclk);
    apb(1'b1, A0, 32'h02);
    rchk(A0, 32'h82);
    apb(1'b1, A0, 32'h82);
    wait_sample(FIRST);
    apb(1'b1, ST, 32'h1);
  endtask
  task automatic t_repeat;
    int n;
    apb(1'b1, A0, 32'h95);
    wait_sample(FIRST);
    wait_sample(REP);
    rchk(A0, 32'h15);
    // Keep the clearing write off the completion edge so one result is owed
    repeat (2) @(negedge pclk);
    apb(1'b1, A0, 32'h05);
    n = 0;
    repeat (4 * REP) begin
      @(negedge pclk);
      if (core_sample === 1'b1) n++;
    end
    check(n, 1);
    check(core_busy, 1'b0);
  endtask
  task automatic t_disable;
    apb(1'b1, A1, 32'h01);
    check(irq, 1'b1);
    apb(1'b1, A0, 32'h83);
    check(core_busy, 1'b0);
    apb(1'b1, ST, 32'h1);
    repeat (FIRST + 2) @(negedge pclk);
    check(irq, 1'b0);
    apb(1'b1, A1, 32'h81);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_refs();
    apb(1'b1, MK, 32'h1);
    t_single(4'h3, FIRST);
    t_single(`ACC_TEMP_CHANNEL, 2 * FIRST);
    t_restart();
    t_repeat();
    t_disable();
    give_verdict();
  end
  // Hang guard, well beyond the few hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
endmodule // tb_top
